// ---- hdl/ucmc_top.sv ----
/*
  Mode and configuration control of the USB high-speed conditioner:
  strap capture, disable-pin shutdown, I2C register slave and the
  link-side speed/compensation state machine.
  Assumes straps, SCL, SDA and the disable pin are asynchronous pins;
  i_usb_speed comes from line logic clocked by i_link_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module ucmc_top (
  input  wire logic       i_sys_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_link_clk,
  input  wire logic       i_active_low_disable_in_n,
  input  wire logic [1:0] i_ac_gain_strap,
  input  wire logic [1:0] i_dc_gain_strap,
  input  wire logic       i_scl,
  input  wire logic       i_sda_in,
  input  wire logic [1:0] i_usb_speed,
  output logic            o_sda_out,
  output logic            o_sda_oe,
  output logic            o_connect_detect_out,
  output logic            o_comp_en,
  output logic            o_bypass,
  output logic [2:0]      o_ac_gain_level,
  output logic [2:0]      o_dc_gain_level
);

  // ---------------------------------------------------------------
  // reset synchronisers
  // ---------------------------------------------------------------
  logic [1:0] srst_q;
  logic [1:0] lrst_q;
  logic       rst_n;
  logic       lrst_n;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) srst_q <= 2'h0;
    else         srst_q <= {srst_q[0], 1'b1};
  end

  always_ff @(posedge i_link_clk or negedge i_nrst) begin
    if (!i_nrst) lrst_q <= 2'h0;
    else         lrst_q <= {lrst_q[0], 1'b1};
  end

  assign rst_n  = srst_q[1];
  assign lrst_n = lrst_q[1];

  // ---------------------------------------------------------------
  // pin filters
  // ---------------------------------------------------------------
  logic       dis_n_f;
  logic       scl_f;
  logic       sda_f;
  logic [1:0] ac_strap_f;
  logic [1:0] dc_strap_f;

  // resets to idle pin levels, so no false scl edge or start follows reset
  ucmc_sync #(.W(7), .RST_VAL(7'h71)) u_pin_sync (
    .i_clk   (i_sys_clk),
    .i_rst_n (rst_n),
    .i_d     ({i_active_low_disable_in_n, i_scl, i_sda_in, i_ac_gain_strap, i_dc_gain_strap}),
    .o_q     ({dis_n_f, scl_f, sda_f, ac_strap_f, dc_strap_f})
  );

  function automatic logic [2:0] ac_code(input logic [1:0] lvl);
    case (lvl)
      2'h0:    ac_code = ucmc_pkg::AC_LVL0;
      2'h1:    ac_code = ucmc_pkg::AC_LVL1;
      2'h2:    ac_code = ucmc_pkg::AC_LVL2;
      default: ac_code = ucmc_pkg::AC_LVL3;
    endcase
  endfunction

  // undefined strap code falls back to the mid level
  function automatic logic [2:0] dc_code(input logic [1:0] lvl);
    case (lvl)
      ucmc_pkg::DC_STRAP_LOW:  dc_code = ucmc_pkg::DC_40MV;
      ucmc_pkg::DC_STRAP_HIGH: dc_code = ucmc_pkg::DC_80MV;
      default:                 dc_code = ucmc_pkg::DC_60MV;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // control state: reset, strap sample, run, shutdown
  // ---------------------------------------------------------------
  ucmc_pkg::ucmc_ctl_e ctl_q;
  logic [3:0]          settle_q;
  logic [11:0]         low_cnt_q;
  logic                sample_done;
  logic                pulse_ok;
  logic                i2c_mode_q;

  assign sample_done = (ctl_q == ucmc_pkg::CTL_SAMPLE) && (settle_q == ucmc_pkg::SETTLE_LAST);
  assign pulse_ok    = !dis_n_f && (low_cnt_q == ucmc_pkg::PULSE_LAST);

  // short glitches on the disable pin never take run to shutdown; in strap sample one goes through reset to shutdown
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n)                                low_cnt_q <= '0;
    else if (dis_n_f)                          low_cnt_q <= '0;
    else if (low_cnt_q != ucmc_pkg::PULSE_LAST) low_cnt_q <= low_cnt_q + 12'h001;
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q    <= ucmc_pkg::CTL_RESET;
      settle_q <= '0;
    end else begin
      case (ctl_q)
        ucmc_pkg::CTL_RESET: begin
          settle_q <= '0;
          ctl_q    <= dis_n_f ? ucmc_pkg::CTL_SAMPLE : ucmc_pkg::CTL_SHUT;
        end
        ucmc_pkg::CTL_SAMPLE: begin
          settle_q <= settle_q + 4'h1;
          if (!dis_n_f)         ctl_q <= ucmc_pkg::CTL_RESET;
          else if (sample_done) ctl_q <= ucmc_pkg::CTL_RUN;
        end
        ucmc_pkg::CTL_RUN: begin
          if (pulse_ok) ctl_q <= ucmc_pkg::CTL_SHUT;
        end
        ucmc_pkg::CTL_SHUT: begin
          settle_q <= '0;
          if (dis_n_f) ctl_q <= ucmc_pkg::CTL_SAMPLE;
        end
        default: ctl_q <= ucmc_pkg::CTL_RESET;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n)           i2c_mode_q <= 1'b0;
    else if (sample_done) i2c_mode_q <= scl_f && sda_f;
  end

  // ---------------------------------------------------------------
  // I2C slave, oversampled on the system clock
  // ---------------------------------------------------------------
  ucmc_pkg::ucmc_i2c_e is_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic       rd_q;
  logic       nack_q;
  logic       sda_oe_q;
  logic       sda_out_q;
  logic       scl_p_q;
  logic       sda_p_q;
  logic       i2c_on;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic       byte_end;
  logic       wr_en;
  logic [2:0] ac_q;
  logic [2:0] dc_q;
  logic       hold_q;
  logic [7:0] rd_now;
  logic [7:0] rd_nxt;

  assign i2c_on   = i2c_mode_q && (ctl_q == ucmc_pkg::CTL_RUN);
  assign scl_rise = scl_f && !scl_p_q;
  assign scl_fall = !scl_f && scl_p_q;
  assign start_c  = scl_f && scl_p_q && sda_p_q && !sda_f;
  assign stop_c   = scl_f && scl_p_q && !sda_p_q && sda_f;
  assign byte_end = scl_fall && (bit_cnt_q == ucmc_pkg::BITS_PER_BYTE);
  assign wr_en    = i2c_on && (is_q == ucmc_pkg::IS_WDATA) && byte_end;

  // reserved bits always read as their zero default
  function automatic logic [7:0] rd_reg(input logic [7:0] ofs);
    case (ofs)
      ucmc_pkg::AC_GAIN_OFS:  rd_reg = {1'b0, ac_q, 4'h0};
      ucmc_pkg::CFG_HOLD_OFS: rd_reg = {7'h00, hold_q};
      ucmc_pkg::DC_GAIN_OFS:  rd_reg = {5'h00, dc_q};
      default:                rd_reg = 8'h00;
    endcase
  endfunction

  // always_comb also follows the fields read inside rd_reg
  always_comb begin
    rd_now = rd_reg(ptr_q);
    rd_nxt = rd_reg(ptr_q + 8'h01);
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
    end
  end

  // sda is open drain: out stays low, only the enable moves
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) sda_out_q <= 1'b0;
    else        sda_out_q <= 1'b0;
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      is_q      <= ucmc_pkg::IS_IDLE;
      bit_cnt_q <= '0;
      sh_q      <= '0;
      tx_q      <= '0;
      ptr_q     <= '0;
      rd_q      <= 1'b0;
      nack_q    <= 1'b0;
      sda_oe_q  <= 1'b0;
    end else if (!i2c_on || stop_c) begin
      is_q     <= ucmc_pkg::IS_IDLE;
      sda_oe_q <= 1'b0;
    end else if (start_c) begin
      is_q      <= ucmc_pkg::IS_ADDR;
      bit_cnt_q <= '0;
      sda_oe_q  <= 1'b0;
    end else if (scl_rise) begin
      sh_q      <= {sh_q[6:0], sda_f};
      bit_cnt_q <= bit_cnt_q + 4'h1;
      if (is_q == ucmc_pkg::IS_RACK) nack_q <= sda_f;
    end else if (scl_fall) begin
      case (is_q)
        ucmc_pkg::IS_ADDR: begin
          if (byte_end) begin
            if (sh_q[7:1] == ucmc_pkg::I2C_ADDR) begin
              is_q     <= ucmc_pkg::IS_ADDR_ACK;
              rd_q     <= sh_q[0];
              sda_oe_q <= 1'b1;
            end else begin
              is_q <= ucmc_pkg::IS_IDLE;
            end
          end
        end
        ucmc_pkg::IS_ADDR_ACK: begin
          bit_cnt_q <= '0;
          if (rd_q) begin
            is_q     <= ucmc_pkg::IS_RDATA;
            tx_q     <= rd_now;
            sda_oe_q <= !rd_now[7];
          end else begin
            is_q     <= ucmc_pkg::IS_PTR;
            sda_oe_q <= 1'b0;
          end
        end
        ucmc_pkg::IS_PTR: begin
          if (byte_end) begin
            ptr_q    <= sh_q;
            is_q     <= ucmc_pkg::IS_PTR_ACK;
            sda_oe_q <= 1'b1;
          end
        end
        ucmc_pkg::IS_PTR_ACK, ucmc_pkg::IS_WACK: begin
          bit_cnt_q <= '0;
          is_q      <= ucmc_pkg::IS_WDATA;
          sda_oe_q  <= 1'b0;
        end
        ucmc_pkg::IS_WDATA: begin
          if (byte_end) begin
            ptr_q    <= ptr_q + 8'h01;
            is_q     <= ucmc_pkg::IS_WACK;
            sda_oe_q <= 1'b1;
          end
        end
        ucmc_pkg::IS_RDATA: begin
          if (byte_end) begin
            is_q     <= ucmc_pkg::IS_RACK;
            sda_oe_q <= 1'b0;
          end else begin
            tx_q     <= {tx_q[6:0], 1'b0};
            sda_oe_q <= !tx_q[6];
          end
        end
        ucmc_pkg::IS_RACK: begin
          bit_cnt_q <= '0;
          if (nack_q) begin
            is_q <= ucmc_pkg::IS_IDLE;
          end else begin
            ptr_q    <= ptr_q + 8'h01;
            is_q     <= ucmc_pkg::IS_RDATA;
            tx_q     <= rd_nxt;
            sda_oe_q <= !rd_nxt[7];
          end
        end
        default: is_q <= ucmc_pkg::IS_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // register fields; strap capture wins over a bus write
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ac_q <= ucmc_pkg::AC_LVL0;
      dc_q <= ucmc_pkg::DC_60MV;
    end else if (sample_done) begin
      ac_q <= ac_code(ac_strap_f);
      dc_q <= dc_code(dc_strap_f);
    end else if (wr_en && ptr_q == ucmc_pkg::AC_GAIN_OFS) begin
      ac_q <= sh_q[ucmc_pkg::AC_GAIN_LSB +: 3];
    end else if (wr_en && ptr_q == ucmc_pkg::DC_GAIN_OFS) begin
      dc_q <= sh_q[ucmc_pkg::DC_GAIN_LSB +: 3];
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n)                                 hold_q <= ucmc_pkg::CFG_HOLD_RST;
    else if (ctl_q != ucmc_pkg::CTL_RUN && !sample_done) hold_q <= ucmc_pkg::CFG_HOLD_RST;
    else if (sample_done)                       hold_q <= scl_f && sda_f;
    else if (wr_en && ptr_q == ucmc_pkg::CFG_HOLD_OFS) hold_q <= sh_q[ucmc_pkg::CFG_HOLD_BIT];
  end

  // ---------------------------------------------------------------
  // gains to the link domain by toggle handshake
  // ---------------------------------------------------------------
  logic       xreq_q;
  logic [5:0] xdata_q;
  logic       xack_s;
  logic       lack_q;
  logic       xreq_s;
  logic       run_q;
  logic       shut_q;
  logic       run_s;
  logic       shut_s;

  // new words only leave once the last one was taken
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      xreq_q  <= 1'b0;
      xdata_q <= '0;
    end else if (xack_s == xreq_q && {ac_q, dc_q} != xdata_q) begin
      xreq_q  <= !xreq_q;
      xdata_q <= {ac_q, dc_q};
    end
  end

  // run waits for the gain word, so a restart never uses stale gains
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q  <= 1'b0;
      shut_q <= 1'b1;
    end else begin
      run_q  <= (ctl_q == ucmc_pkg::CTL_RUN) && !hold_q && (xack_s == xreq_q)
                && ({ac_q, dc_q} == xdata_q);
      shut_q <= (ctl_q != ucmc_pkg::CTL_RUN);
    end
  end

  ucmc_sync #(.W(1), .RST_VAL(1'b0)) u_ack_sync (
    .i_clk   (i_sys_clk),
    .i_rst_n (rst_n),
    .i_d     (lack_q),
    .o_q     (xack_s)
  );

  ucmc_sync #(.W(3), .RST_VAL(3'h2)) u_link_sync (
    .i_clk   (i_link_clk),
    .i_rst_n (lrst_n),
    .i_d     ({xreq_q, shut_q, run_q}),
    .o_q     ({xreq_s, shut_s, run_s})
  );

  // ---------------------------------------------------------------
  // link domain: speed state machine and conditioner controls
  // ---------------------------------------------------------------
  ucmc_pkg::ucmc_link_e ls_q;
  ucmc_pkg::ucmc_link_e ls_d;
  logic [5:0] gains_q;
  logic       cd_q;
  logic       comp_q;
  logic       bypass_q;
  logic [2:0] ac_out_q;
  logic [2:0] dc_out_q;

  always_ff @(posedge i_link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      gains_q <= '0;
      lack_q  <= 1'b0;
    end else if (xreq_s != lack_q) begin
      gains_q <= xdata_q;
      lack_q  <= xreq_s;
    end
  end

  always_comb begin
    ls_d = ls_q;
    if (shut_s || !run_s) begin
      ls_d = ucmc_pkg::LS_OFF;
    end else begin
      case (i_usb_speed)
        ucmc_pkg::SPD_LS, ucmc_pkg::SPD_FS: ls_d = ucmc_pkg::LS_LSFS;
        ucmc_pkg::SPD_HS:                   ls_d = ucmc_pkg::LS_HS;
        default:                            ls_d = ucmc_pkg::LS_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      ls_q     <= ucmc_pkg::LS_OFF;
      cd_q     <= 1'b0;
      comp_q   <= 1'b0;
      bypass_q <= 1'b1;
      ac_out_q <= '0;
      dc_out_q <= '0;
    end else begin
      ls_q     <= ls_d;
      cd_q     <= (ls_d == ucmc_pkg::LS_LSFS) || (ls_d == ucmc_pkg::LS_HS);
      comp_q   <= (ls_d == ucmc_pkg::LS_HS);
      bypass_q <= (ls_d != ucmc_pkg::LS_HS);
      ac_out_q <= (ls_d == ucmc_pkg::LS_HS) ? gains_q[5:3] : 3'h0;
      dc_out_q <= (ls_d == ucmc_pkg::LS_HS) ? gains_q[2:0] : 3'h0;
    end
  end

  assign o_sda_out            = sda_out_q;
  assign o_sda_oe             = sda_oe_q;
  assign o_connect_detect_out = cd_q;
  assign o_comp_en            = comp_q;
  assign o_bypass             = bypass_q;
  assign o_ac_gain_level      = ac_out_q;
  assign o_dc_gain_level      = dc_out_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_low_2(logic [1:0] spd);
    run_s && !shut_s && i_usb_speed == spd ##1 run_s && !shut_s && i_usb_speed == spd;
  endsequence

  AST_LS_NO_COMP: assert property (@(posedge i_link_clk) disable iff (!lrst_n)
    s_low_2(ucmc_pkg::SPD_LS) |-> cd_q && !comp_q) else $error("ls comp wrong");
  AST_FS_NO_COMP: assert property (@(posedge i_link_clk) disable iff (!lrst_n)
    s_low_2(ucmc_pkg::SPD_FS) |-> cd_q && !comp_q && bypass_q) else $error("fs comp wrong");
  AST_HS_COMP: assert property (@(posedge i_link_clk) disable iff (!lrst_n)
    s_low_2(ucmc_pkg::SPD_HS) |-> cd_q && comp_q && ac_out_q == gains_q[5:3])
    else $error("hs comp wrong");
  AST_NOCONN_LOW: assert property (@(posedge i_link_clk) disable iff (!lrst_n)
    s_low_2(ucmc_pkg::SPD_NONE) |-> !cd_q) else $error("detect high with no link");
  AST_SHUT_QUIET: assert property (@(posedge i_link_clk) disable iff (!lrst_n)
    shut_s |=> !cd_q && !comp_q && bypass_q) else $error("status in shutdown");
  AST_SHUT_PULSE: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    $rose(ctl_q == ucmc_pkg::CTL_SHUT) && $past(ctl_q) == ucmc_pkg::CTL_RUN
    |-> $past(low_cnt_q) == ucmc_pkg::PULSE_LAST && !$past(dis_n_f))
    else $error("shutdown on short pulse");
  AST_STRAP_LOAD: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    sample_done |=> ac_q == ac_code($past(ac_strap_f)) && dc_q == dc_code($past(dc_strap_f)))
    else $error("strap not loaded");
  AST_STRAP_IGNORED: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    ctl_q == ucmc_pkg::CTL_RUN && $past(ctl_q) == ucmc_pkg::CTL_RUN && !$past(wr_en)
    |-> $stable(ac_q) && $stable(dc_q)) else $error("gain moved without write");
  AST_HOLD_AUTO: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    sample_done |=> hold_q == i2c_mode_q) else $error("hold bit wrong after reset");
  AST_ADDR_ACK: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    i2c_on && !stop_c && !start_c && is_q == ucmc_pkg::IS_ADDR && byte_end
    |=> sda_oe_q == (($past(sh_q) >> 1) == {1'b0, ucmc_pkg::I2C_ADDR}))
    else $error("address ack wrong");
  AST_NO_I2C: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
    !i2c_mode_q |-> !sda_oe_q) else $error("sda driven outside i2c mode");

endmodule

`default_nettype wire

// ---- hdl/ucmc_pkg.sv ----
/*
  Constants and types for the USB conditioner mode/config block.
  Assumes a 125 MHz system clock and a separate link clock domain.
*/
package ucmc_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [6:0] I2C_ADDR      = 7'h2C;
  localparam logic [7:0] AC_GAIN_OFS   = 8'h01;
  localparam logic [7:0] CFG_HOLD_OFS  = 8'h03;
  localparam logic [7:0] DC_GAIN_OFS   = 8'h0E;
  localparam int         AC_GAIN_LSB   = 4;
  localparam int         CFG_HOLD_BIT  = 0;
  localparam int         DC_GAIN_LSB   = 0;
  localparam logic       CFG_HOLD_RST  = 1'b1;
  localparam logic [2:0] AC_LVL0       = 3'h0;
  localparam logic [2:0] AC_LVL1       = 3'h1;
  localparam logic [2:0] AC_LVL2       = 3'h3;
  localparam logic [2:0] AC_LVL3       = 3'h7;
  localparam logic [2:0] DC_40MV       = 3'h3;
  localparam logic [2:0] DC_60MV       = 3'h5;
  localparam logic [2:0] DC_80MV       = 3'h7;

  // ---------------------------------------------------------------
  // pin encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] DC_STRAP_LOW  = 2'h0;
  localparam logic [1:0] DC_STRAP_HIGH = 2'h2;
  localparam logic [1:0] SPD_NONE      = 2'h0;
  localparam logic [1:0] SPD_LS        = 2'h1;
  localparam logic [1:0] SPD_FS        = 2'h2;
  localparam logic [1:0] SPD_HS        = 2'h3;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int         SYS_CLK_KHZ   = 125000;
  localparam int         I2C_RATE_KHZ  = 100;
  localparam int         PULSE_MIN_US  = 20;
  localparam int         PULSE_CYC     = (PULSE_MIN_US * SYS_CLK_KHZ + 999) / 1000;
  localparam int         LOW_CNT_W     = 12;
  localparam logic [11:0] PULSE_LAST   = 12'(PULSE_CYC - 1);
  localparam logic [3:0] SETTLE_LAST   = 4'h7;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ---------------------------------------------------------------
  // state types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CTL_RESET  = 2'h0,
    CTL_SAMPLE = 2'h1,
    CTL_RUN    = 2'h3,
    CTL_SHUT   = 2'h2
  } ucmc_ctl_e;

  typedef enum logic [3:0] {
    IS_IDLE     = 4'h0,
    IS_ADDR     = 4'h1,
    IS_ADDR_ACK = 4'h3,
    IS_PTR      = 4'h2,
    IS_PTR_ACK  = 4'h6,
    IS_WDATA    = 4'h7,
    IS_WACK     = 4'h5,
    IS_RDATA    = 4'h4,
    IS_RACK     = 4'hC
  } ucmc_i2c_e;

  typedef enum logic [1:0] {
    LS_OFF  = 2'h0,
    LS_IDLE = 2'h1,
    LS_LSFS = 2'h3,
    LS_HS   = 2'h2
  } ucmc_link_e;

endpackage

// ---- hdl/ucmc_sync.sv ----
/*
  Three-stage pin/level synchroniser with agreement filter.
  Assumes i_d is asynchronous to i_clk; o_q moves once stages two and
  three agree.
*/
`timescale 1ns/1ps
`default_nettype none

module ucmc_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] q_q;

  // s1 is read by s2 only
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else begin
      s1_q <= i_d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          q_q[g] <= RST_VAL[g];
        end else if (s2_q[g] == s3_q[g]) begin
          q_q[g] <= s3_q[g];
        end
      end
    end
  endgenerate

  assign o_q = q_q;

endmodule

`default_nettype wire

// ---- test/ucmc_i2c_ctl.sv ----
/*
  Behavioural I2C bus controller for the conditioner's SCL/SDA pins.
  Assumes a pull-up on SDA: o_sda high means released.
*/
`timescale 1ns/1ps
`default_nettype none

module ucmc_i2c_ctl (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1; // idle high at wake so I2C mode is taken
  end

  // 625 cycles a half bit keeps the bus at 100 kHz
  task automatic hp();
    repeat (625) @(negedge i_clk);
  endtask

  task automatic start();
    o_sda = 1'b0;
    hp();
    o_scl = 1'b0;
    hp();
  endtask

  task automatic stop();
    o_sda = 1'b0;
    hp();
    o_scl = 1'b1;
    hp();
    o_sda = 1'b1;
    hp();
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      o_sda = b[i];
      hp();
      o_scl = 1'b1;
      hp();
      o_scl = 1'b0;
    end
    o_sda = 1'b1;
    hp();
    o_scl = 1'b1;
    ack = !i_sda;
    hp();
    o_scl = 1'b0;
  endtask

  // bits are taken at scl rise; the ninth bit is our ack or nack
  task automatic get_byte(input logic nack, output logic [7:0] b);
    o_sda = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      hp();
      o_scl = 1'b1;
      b[i] = i_sda;
      hp();
      o_scl = 1'b0;
    end
    o_sda = nack;
    hp();
    o_scl = 1'b1;
    hp();
    o_scl = 1'b0;
  endtask

  // holds sda at a level outside transfers, e.g. to refuse I2C mode
  task automatic set_sda(input logic v);
    o_sda = v;
  endtask
endmodule

`default_nettype wire

// ---- test/test_usb_conditioner_mode_config.sv ----
/*
  Bench for ucmc_top: hold release over I2C, speed modes, shutdown.
  Assumes ucmc_i2c_ctl as bus controller and a pull-up on SDA.
*/
`timescale 1ns/1ps
`default_nettype none

module test_usb_conditioner_mode_config;
  logic       sys_clk = 1'b0;
  logic       link_clk = 1'b0;
  logic       nrst = 1'b0;
  logic       dis_n = 1'b1;
  logic [1:0] spd = 2'h0;
  logic [1:0] ac_strap = 2'h2;
  logic [1:0] dc_strap = 2'h1;
  logic [2:0] exp_ac = ucmc_pkg::AC_LVL2;
  logic [2:0] exp_dc = ucmc_pkg::DC_60MV;
  logic [7:0] rd;
  logic       scl, sda_c, sda_oe, sda_out, cd, comp, byp, ack;
  logic [2:0] ac, dc;
  logic [7:0] msg [3];
  wire        sda = sda_c & ~sda_oe;
  wire  [8:0] obs = {cd, comp, byp, ac, dc};
  int         errors = 0;
  int         n_checks = 0;

  always #4 sys_clk = ~sys_clk;
  always #3 link_clk = ~link_clk;

  ucmc_i2c_ctl u_ctl (.i_clk(sys_clk), .i_sda(sda), .o_scl(scl), .o_sda(sda_c));

  ucmc_top u_dut (
    .i_sys_clk(sys_clk), .i_nrst(nrst), .i_link_clk(link_clk),
    .i_active_low_disable_in_n(dis_n), .i_ac_gain_strap(ac_strap),
    .i_dc_gain_strap(dc_strap), .i_scl(scl), .i_sda_in(sda), .i_usb_speed(spd),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_connect_detect_out(cd),
    .o_comp_en(comp), .o_bypass(byp), .o_ac_gain_level(ac), .o_dc_gain_level(dc));

  function automatic logic [8:0] exp_link(input logic [1:0] s, input logic run);
    logic hs;
    hs = run && (s == ucmc_pkg::SPD_HS);
    return {run && (s != ucmc_pkg::SPD_NONE), hs, !hs,
            hs ? exp_ac : 3'h0, hs ? exp_dc : 3'h0};
  endfunction

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic set_spd(input logic [1:0] s);
    @(negedge link_clk);
    spd = s;
    repeat (4) @(negedge link_clk);
  endtask

  initial begin
    repeat (6) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (40) @(negedge sys_clk);
    set_spd(ucmc_pkg::SPD_HS);
    check(obs, exp_link(ucmc_pkg::SPD_HS, 1'b0));
    u_ctl.start();
    u_ctl.put_byte({7'h2D, 1'b0}, ack);
    u_ctl.stop();
    check({8'h00, ack}, 9'h000);
    $display("test wrong address done");
    msg = '{{ucmc_pkg::I2C_ADDR, 1'b0}, ucmc_pkg::CFG_HOLD_OFS, 8'h00};
    u_ctl.start();
    foreach (msg[i]) begin
      u_ctl.put_byte(msg[i], ack);
      check({8'h00, ack}, 9'h001);
    end
    u_ctl.stop();
    u_ctl.start();
    u_ctl.put_byte({ucmc_pkg::I2C_ADDR, 1'b1}, ack);
    u_ctl.get_byte(1'b1, rd);
    u_ctl.stop();
    check({ack, rd}, 9'h100);
    $display("test read done");
    for (int s = 0; s < 4; s++) begin
      set_spd(2'(s));
      check(obs, exp_link(2'(s), 1'b1));
    end
    $display("test speed modes done");
    @(negedge sys_clk);
    ac_strap = 2'h3;
    dc_strap = 2'h2;
    dis_n = 1'b0;
    repeat (100) @(negedge sys_clk);
    dis_n = 1'b1;
    repeat (40) @(negedge sys_clk);
    check(obs, exp_link(ucmc_pkg::SPD_HS, 1'b1));
    dis_n = 1'b0;
    repeat (2600) @(negedge sys_clk);
    check(obs, exp_link(ucmc_pkg::SPD_HS, 1'b0));
    dis_n = 1'b1;
    repeat (60) @(negedge sys_clk);
    check(obs, exp_link(ucmc_pkg::SPD_HS, 1'b0));
    exp_ac = ucmc_pkg::AC_LVL3;
    exp_dc = ucmc_pkg::DC_80MV;
    dis_n = 1'b0;
    u_ctl.set_sda(1'b0);
    repeat (2600) @(negedge sys_clk);
    dis_n = 1'b1;
    repeat (60) @(negedge sys_clk);
    check(obs, exp_link(ucmc_pkg::SPD_HS, 1'b1));
    u_ctl.set_sda(1'b1);
    $display("test shutdown done");
    wrap_up();
  end

  initial begin
    repeat (90000) @(posedge sys_clk);
    errors++;
    wrap_up();
  end
endmodule

`default_nettype wire
